// *** rtl/osct_ctrl.sv ***
// Oscillator control: crystal trim apply, ready/settle flags, reference counter.
// Assumes all ticks are one-cycle enables synchronous to the 25 MHz i_clk.
// What this block does
// - 8-bit trim, 0x00 fastest, 0xff slowest
// - Low five trim bits drive binary enables
// - High three bits thermometer-decode into seven enables
// - Ready interrupt when ready counter hits threshold
// - Ready counter ticks fast RC or low-power clock
// - Hardware enables fast crystal during sequence
// - Counter mode applies trim at limit minus one
// - Current mode applies trim on current drop
// - Trim applied by hardware, no software write
// - Current mode captures ready counter on apply
// - Settle-ready flag at settle threshold
// - Slow RC switches to 512 kHz during sequence
// - Source select decodes four clock sources
// - Go bit held until measurement ends
// - Reference count M over N cycles, 32 bits
//
// Decided for this implementation: the register offsets and register access over APB.
`default_nettype none
module osct_ctrl
  import osct_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_powerup_start,
  input  wire logic        i_wakeup_start,
  input  wire logic        i_fast_rc_tick,
  input  wire logic        i_lp_tick,
  input  wire logic        i_osc_current_drop,
  input  wire logic        i_ref_tick,
  input  wire logic [3:0]  i_cal_src_tick,
  output logic      [4:0]  o_cap_binary,
  output logic      [6:0]  o_cap_thermo,
  output logic             o_crystal_ready_irq,
  output logic             o_fast_xtal_en,
  output logic             o_slow_rc_fast,
  output logic             o_trim_applied_flag,
  output logic             o_settle_ready_flag
);
  osct_state_t      state;
  osct_state_t      next_state;
  logic [7:0]       crystal_trim_setting;
  logic [7:0]       stored_trim_value;
  logic [CNT_W-1:0] ready_count_threshold;
  logic [CNT_W-1:0] ready_cnt;
  logic [CNT_W-1:0] ready_count_capture;
  logic [7:0]       startup_count_limit;
  logic [7:0]       settle_threshold;
  logic [7:0]       startup_cnt;
  logic [7:0]       settle_counter;
  logic             trim_apply_select;
  logic             is_wake;
  logic             irq_done;
  logic [31:0]      general_scratch_word;
  logic [15:0]      calib_cycle_count;
  logic [15:0]      meas_cnt;
  logic [31:0]      ref_cnt;
  logic [31:0]      cal_result;
  osct_src_t        cal_src;
  logic             cal_go;
  logic             cal_src_tick;
  logic             cal_start;
  logic             cal_done;
  logic             seq_start;
  logic             seq_tick;
  logic             apply;
  logic             ready_hit;
  logic             settle_hit;
  logic             acc;
  logic             wr_en;
  logic             mapped;
  logic [31:0]      rd_data;

  // Sequence control
  assign seq_start  = i_powerup_start | i_wakeup_start;
  assign seq_tick   = is_wake ? i_lp_tick : i_fast_rc_tick;
  assign apply      = (state == ST_STARTUP) && (trim_apply_select
                      ? i_osc_current_drop
                      : (seq_tick && startup_cnt == 8'(startup_count_limit - 8'h01)));
  assign ready_hit  = (state != ST_IDLE) && !irq_done && (ready_cnt == ready_count_threshold);
  assign settle_hit = (state == ST_SETTLE) && (settle_counter == settle_threshold);

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE:    if (seq_start) next_state = ST_STARTUP;
      ST_STARTUP: if (apply) next_state = ST_SETTLE;
      ST_SETTLE:  if (settle_hit) next_state = ST_RUN;
      ST_RUN:     if (seq_start) next_state = ST_STARTUP;
      default:    next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state          <= ST_IDLE;
      o_fast_xtal_en <= 1'b0;
      o_slow_rc_fast <= 1'b0;
    end else begin
      state          <= next_state;
      o_fast_xtal_en <= (next_state != ST_IDLE);
      o_slow_rc_fast <= (next_state == ST_STARTUP) || (next_state == ST_SETTLE);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      is_wake        <= 1'b0;
      startup_cnt    <= 8'h00;
      settle_counter <= 8'h00;
    end else if (seq_start && (state == ST_IDLE || state == ST_RUN)) begin
      is_wake        <= i_wakeup_start;
      startup_cnt    <= 8'h00;
    end else begin
      if (state == ST_STARTUP && seq_tick) startup_cnt <= 8'(startup_cnt + 8'h01);
      if (apply) settle_counter <= 8'h00;
      else if (state == ST_SETTLE && seq_tick) settle_counter <= 8'(settle_counter + 8'h01);
    end
  end

  // Ready counter, interrupt and capture
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ready_cnt           <= '0;
      irq_done            <= 1'b0;
      o_crystal_ready_irq <= 1'b0;
      ready_count_capture <= '0;
    end else begin
      o_crystal_ready_irq <= ready_hit;
      if (seq_start && (state == ST_IDLE || state == ST_RUN)) begin
        ready_cnt <= '0;
        irq_done  <= 1'b0;
      end else if (ready_hit) begin
        irq_done  <= 1'b1;
      end else if (state != ST_IDLE && !irq_done && seq_tick) begin
        ready_cnt <= CNT_W'(ready_cnt + 1'b1);
      end
      if (apply && trim_apply_select) ready_count_capture <= ready_cnt;
    end
  end

  // Trim apply and settle flags
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      crystal_trim_setting <= RST_TRIM;
      o_trim_applied_flag  <= 1'b0;
      o_settle_ready_flag  <= 1'b0;
    end else begin
      if (apply) crystal_trim_setting <= stored_trim_value;
      else if (wr_en && i_paddr == ADDR_TRIM_SET) crystal_trim_setting <= i_pwdata[7:0];
      if (apply) o_trim_applied_flag <= 1'b1;
      else if (seq_start && state != ST_STARTUP && state != ST_SETTLE)
        o_trim_applied_flag <= 1'b0;
      if (settle_hit) o_settle_ready_flag <= 1'b1;
      else if (seq_start && state != ST_STARTUP && state != ST_SETTLE)
        o_settle_ready_flag <= 1'b0;
    end
  end

  osct_trim_decode u_dec (
    .i_clk        (i_clk),
    .i_srst       (i_srst),
    .i_code       (crystal_trim_setting),
    .o_cap_binary (o_cap_binary),
    .o_cap_thermo (o_cap_thermo)
  );

  // Reference counter
  always_comb begin
    case (cal_src)
      SRC_SLOW_RC:   cal_src_tick = i_cal_src_tick[0];
      SRC_FAST_RC:   cal_src_tick = i_cal_src_tick[1];
      SRC_SLOW_XTAL: cal_src_tick = i_cal_src_tick[2];
      SRC_ENH_RC:    cal_src_tick = i_cal_src_tick[3];
      default:       cal_src_tick = 1'b0;
    endcase
  end

  assign cal_start = wr_en && (i_paddr == ADDR_CAL_SEL) && i_pwdata[CAL_GO_BIT] && !cal_go;
  assign cal_done  = cal_go && ((calib_cycle_count == 16'h0000)
                     || (cal_src_tick && meas_cnt == 16'(calib_cycle_count - 16'h0001)));

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cal_go     <= 1'b0;
      meas_cnt   <= 16'h0000;
      ref_cnt    <= 32'h0000_0000;
      cal_result <= 32'h0000_0000;
    end else if (cal_start) begin
      cal_go   <= 1'b1;
      meas_cnt <= 16'h0000;
      ref_cnt  <= 32'h0000_0000;
    end else if (cal_done) begin
      cal_go     <= 1'b0;
      cal_result <= ref_cnt;
    end else if (cal_go) begin
      if (cal_src_tick) meas_cnt <= 16'(meas_cnt + 16'h0001);
      if (i_ref_tick) ref_cnt <= 32'(ref_cnt + 32'h0000_0001);
    end
  end

  // APB slave: one wait state, error on unmapped address
  assign acc   = i_psel && i_penable;
  assign wr_en = acc && o_pready && i_pwrite && !o_pslverr;

  always_comb begin
    rd_data = 32'h0000_0000;
    mapped  = 1'b1;
    case (i_paddr)
      ADDR_TRIM_SET:  rd_data = {24'h0, crystal_trim_setting};
      ADDR_RDY_THR:   rd_data = {16'h0, ready_count_threshold};
      ADDR_TRIM_CTRL: rd_data = {8'h0, settle_threshold, startup_count_limit, 7'h0,
                                 trim_apply_select};
      ADDR_RDY_CAP:   rd_data = {16'h0, ready_count_capture};
      ADDR_STATUS:    rd_data = {28'h0, is_wake, irq_done, o_trim_applied_flag,
                                 o_settle_ready_flag};
      ADDR_SCRATCH:   rd_data = general_scratch_word;
      ADDR_CAL_N:     rd_data = {16'h0, calib_cycle_count};
      ADDR_CAL_SEL:   rd_data = {29'h0, cal_go, cal_src};
      ADDR_CAL_HI:    rd_data = {16'h0, cal_result[31:16]};
      ADDR_CAL_LO:    rd_data = {16'h0, cal_result[15:0]};
      ADDR_STORED:    rd_data = {24'h0, stored_trim_value};
      default:        mapped  = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
    end else begin
      o_pready  <= acc && !o_pready;
      o_pslverr <= acc && !o_pready && !mapped;
      if (acc && !o_pready) o_prdata <= i_pwrite ? 32'h0000_0000 : rd_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      stored_trim_value     <= RST_TRIM;
      ready_count_threshold <= RST_RDY_THR;
      startup_count_limit   <= RST_STARTUP_N;
      settle_threshold      <= RST_SETTLE_N;
      trim_apply_select     <= RST_TRIM_SEL;
      general_scratch_word  <= 32'h0000_0000;
      calib_cycle_count     <= RST_CAL_N;
      cal_src               <= SRC_SLOW_RC;
    end else if (wr_en) begin
      case (i_paddr)
        ADDR_STORED:  stored_trim_value     <= i_pwdata[7:0];
        ADDR_RDY_THR: ready_count_threshold <= i_pwdata[CNT_W-1:0];
        ADDR_TRIM_CTRL: begin
          trim_apply_select   <= i_pwdata[TC_SEL_BIT];
          startup_count_limit <= i_pwdata[TC_STARTUP_LSB +: 8];
          settle_threshold    <= i_pwdata[TC_SETTLE_LSB +: 8];
        end
        ADDR_SCRATCH: general_scratch_word <= i_pwdata;
        ADDR_CAL_N:   if (!cal_go) calib_cycle_count <= i_pwdata[15:0];
        ADDR_CAL_SEL: if (!cal_go) cal_src <= osct_src_t'(i_pwdata[1:0]);
        default: ;
      endcase
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);

  property p_ready_irq;
    ready_hit |=> o_crystal_ready_irq ##1 !o_crystal_ready_irq;
  endproperty
  a_ready_irq: assert property (p_ready_irq) else $error("ready irq missing");

  property p_counter_apply;
    (state == ST_STARTUP && !trim_apply_select && seq_tick
      && startup_cnt == 8'(startup_count_limit - 8'h01))
      |=> o_trim_applied_flag && (state == ST_SETTLE)
      && (crystal_trim_setting == $past(stored_trim_value));
  endproperty
  a_counter_apply: assert property (p_counter_apply) else $error("counter apply wrong");

  property p_current_apply;
    (state == ST_STARTUP && trim_apply_select && i_osc_current_drop)
      |=> o_trim_applied_flag && (ready_count_capture == $past(ready_cnt));
  endproperty
  a_current_apply: assert property (p_current_apply) else $error("current apply bad");

  property p_no_early_apply;
    (state == ST_STARTUP && !trim_apply_select && !seq_tick) |=> state != ST_SETTLE;
  endproperty
  a_no_early_apply: assert property (p_no_early_apply) else $error("early apply");

  property p_settle;
    settle_hit |=> o_settle_ready_flag && (state == ST_RUN);
  endproperty
  a_settle: assert property (p_settle) else $error("settle flag missing");

  property p_xtal_en;
    (state != ST_IDLE) |-> o_fast_xtal_en
      && (o_slow_rc_fast == (state == ST_STARTUP || state == ST_SETTLE));
  endproperty
  a_xtal_en: assert property (p_xtal_en) else $error("oscillator enables bad");

  property p_go_hold;
    (cal_go && !cal_done) |=> cal_go;
  endproperty
  a_go_hold: assert property (p_go_hold) else $error("go bit dropped early");

  property p_cal_result;
    cal_done |=> !cal_go && (cal_result == $past(ref_cnt));
  endproperty
  a_cal_result: assert property (p_cal_result) else $error("calibration result wrong");

  property p_result_stable;
    (!cal_go && !cal_start) |=> $stable(cal_result);
  endproperty
  a_result_stable: assert property (p_result_stable) else $error("result changed");
endmodule
`default_nettype wire

// *** pkg/osct_pkg.sv ***
// Constants for the oscillator trim, settle and calibration block.
// Assumes a single 25 MHz clock and an APB register port.
`default_nettype none
package osct_pkg;
  localparam int CLK_PERIOD_NS = 40;
  localparam int CNT_W         = 16;
  // Register byte offsets
  localparam logic [7:0] ADDR_TRIM_SET  = 8'h00;
  localparam logic [7:0] ADDR_RDY_THR   = 8'h04;
  localparam logic [7:0] ADDR_TRIM_CTRL = 8'h08;
  localparam logic [7:0] ADDR_RDY_CAP   = 8'h0c;
  localparam logic [7:0] ADDR_STATUS    = 8'h10;
  localparam logic [7:0] ADDR_SCRATCH   = 8'h14;
  localparam logic [7:0] ADDR_CAL_N     = 8'h18;
  localparam logic [7:0] ADDR_CAL_SEL   = 8'h1c;
  localparam logic [7:0] ADDR_CAL_HI    = 8'h20;
  localparam logic [7:0] ADDR_CAL_LO    = 8'h24;
  localparam logic [7:0] ADDR_STORED    = 8'h28;
  // Field positions
  localparam int TC_SEL_BIT     = 0;
  localparam int TC_STARTUP_LSB = 8;
  localparam int TC_SETTLE_LSB  = 16;
  localparam int CAL_GO_BIT     = 2;
  // Values after reset
  localparam logic [7:0]       RST_TRIM      = 8'h00;
  localparam logic [CNT_W-1:0] RST_RDY_THR   = 16'h0100;
  localparam logic [7:0]       RST_STARTUP_N = 8'h10;
  localparam logic [7:0]       RST_SETTLE_N  = 8'h08;
  localparam logic             RST_TRIM_SEL  = 1'b0;
  localparam logic [15:0]      RST_CAL_N     = 16'h0040;
  typedef enum logic [1:0] {
    SRC_SLOW_RC   = 2'h0,
    SRC_FAST_RC   = 2'h1,
    SRC_SLOW_XTAL = 2'h2,
    SRC_ENH_RC    = 2'h3
  } osct_src_t;
  typedef enum logic [3:0] {
    ST_IDLE    = 4'h1,
    ST_STARTUP = 4'h2,
    ST_SETTLE  = 4'h4,
    ST_RUN     = 4'h8
  } osct_state_t;
endpackage
`default_nettype wire

// *** rtl/osct_trim_decode.sv ***
// Crystal load-capacitor enable decoder with registered outputs.
// Assumes the trim code is synchronous to i_clk.
`default_nettype none
module osct_trim_decode
  import osct_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_srst,
  input  wire logic [7:0] i_code,
  output logic      [4:0] o_cap_binary,
  output logic      [6:0] o_cap_thermo
);
  logic [6:0] next_thermo;

  genvar g;
  generate
    for (g = 0; g < 7; g++) begin : g_therm
      assign next_thermo[g] = (i_code[7:5] > 3'(g));
    end
  endgenerate

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_cap_binary <= 5'h00;
      o_cap_thermo <= 7'h00;
    end else begin
      o_cap_binary <= i_code[4:0];
      o_cap_thermo <= next_thermo;
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);

  property p_bin_direct;
    ##1 (o_cap_binary == $past(i_code[4:0]));
  endproperty
  a_bin_direct: assert property (p_bin_direct) else $error("binary enables wrong");

  property p_thermo;
    ##1 (($countones(o_cap_thermo) == 32'($past(i_code[7:5])))
      && ((o_cap_thermo & 7'(o_cap_thermo + 7'h01)) == 7'h00));
  endproperty
  a_thermo: assert property (p_thermo) else $error("thermometer wrong");
endmodule
`default_nettype wire

// *** dv/osct_osc_model.sv ***
// Behavioural crystal and RC oscillators: tick enables and current drop.
// Assumes the bench requests the drop; ticks come from a free counter.
`default_nettype none
module osct_osc_model (
  input  wire logic       i_clk,
  input  wire logic       i_srst,
  input  wire logic       i_xtal_en,
  input  wire logic       i_drop_req,
  output logic            o_fast_rc_tick,
  output logic            o_lp_tick,
  output logic            o_ref_tick,
  output logic            o_cur_drop,
  output logic      [3:0] o_src_tick
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt;
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cnt <= 4'h0;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
  // Fast RC and low-power clock ticks, never faster than the bus clock
  assign o_fast_rc_tick = cnt[0];
  assign o_lp_tick      = (cnt[2:0] == 3'h7);
  assign o_ref_tick     = (cnt[1:0] != 2'h0);
  // Current only drops while the crystal is enabled
  assign o_cur_drop     = i_drop_req & i_xtal_en;
  assign o_src_tick     = {cnt == 4'hf, cnt[2:0] == 3'h7, cnt[1:0] == 2'h3, cnt[0]};
endmodule
`default_nettype wire

// *** dv/osct_ctrl_tb.sv ***
// Testbench for osct_ctrl: register table, trim sequences, calibration.
// Assumes osct_osc_model supplies every tick and the current drop.
`default_nettype none
module osct_ctrl_tb
  import osct_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] x;
    logic [11:0] c;
  } osct_row_t;
  logic        clk, srst, psel, penable, pwrite, pu, wk, drop_req, cal_on, irq_seen;
  logic        pready, pslverr, e, fast_t, lp_t, ref_t, drop, irq, xen, rcf, app, stl;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r, hi;
  logic [3:0]  src_t;
  logic [4:0]  capb;
  logic [6:0]  capt;
  int          error_cnt, checks, n, i, tk_app, tk_irq, tk_lp, irq_cnt, cn, cm, cn_lim, cs;
  osct_row_t   rows [12] = '{
    '{8'h00, 32'h00, 32'h00, 12'h000}, '{8'h00, 32'hff, 32'hff, 12'hfff},
    '{8'h00, 32'h1f, 32'h1f, 12'h01f}, '{8'h00, 32'h20, 32'h20, 12'h020},
    '{8'h00, 32'ha5, 32'ha5, 12'h3e5}, '{8'h00, 32'h6c, 32'h6c, 12'h0ec},
    '{8'h14, 32'h20, 32'h20, 12'h0}, '{8'h14, 32'h40, 32'h40, 12'h0},
    '{8'h0c, 32'hffffffff, 32'h0, 12'h0}, '{8'h04, 32'h30, 32'h30, 12'h0},
    '{8'h28, 32'h5a, 32'h5a, 12'h0}, '{8'h08, 32'h00030400, 32'h00030400, 12'h0}};
  osct_row_t   rst_rows [5] = '{
    '{8'h00, 32'h0, 32'h0, 12'h0}, '{8'h04, 32'h0, 32'h100, 12'h0},
    '{8'h08, 32'h0, 32'h00081000, 12'h0}, '{8'h18, 32'h0, 32'h40, 12'h0},
    '{8'h1c, 32'h0, 32'h0, 12'h0}};

  osct_ctrl dut (.i_clk(clk), .i_srst(srst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_powerup_start(pu), .i_wakeup_start(wk),
    .i_fast_rc_tick(fast_t), .i_lp_tick(lp_t), .i_osc_current_drop(drop),
    .i_ref_tick(ref_t), .i_cal_src_tick(src_t), .o_cap_binary(capb), .o_cap_thermo(capt),
    .o_crystal_ready_irq(irq), .o_fast_xtal_en(xen), .o_slow_rc_fast(rcf),
    .o_trim_applied_flag(app), .o_settle_ready_flag(stl));
  osct_osc_model osc (.i_clk(clk), .i_srst(srst), .i_xtal_en(xen), .i_drop_req(drop_req),
    .o_fast_rc_tick(fast_t), .o_lp_tick(lp_t), .o_ref_tick(ref_t), .o_cur_drop(drop),
    .o_src_tick(src_t));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (g !== x) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, x, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic do_row(input osct_row_t w);
    apb(1'b1, w.a, w.d, r, e);
    apb(1'b0, w.a, 32'h0, r, e);
    chk("reg", w.x, r);
    if (w.a == ADDR_TRIM_SET) begin
      chk("cap", {20'h0, w.c}, {20'h0, capt, capb});
    end
  endtask

  task automatic end_sim();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Watches the ports and counts ticks inside each window
  always @(posedge clk) begin
    if (irq === 1'b1) begin
      irq_seen = 1'b1;
      irq_cnt++;
    end
    if (rcf && !app && fast_t) tk_app++;
    if (rcf && !app && lp_t) tk_lp++;
    if (xen && !irq_seen && fast_t) tk_irq++;
    if (cal_on) begin
      if (src_t[cs]) begin
        cn++;
        if (cn == cn_lim) cal_on = 1'b0;
      end
      if (cal_on && ref_t) cm++;
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    end_sim();
  end

  initial begin
    {psel, penable, pwrite, pu, wk, drop_req, cal_on, irq_seen} = '0;
    paddr = 8'h0;
    pwdata = 32'h0;
    srst = 1'b1;
    {error_cnt, checks, tk_app, tk_irq, tk_lp, irq_cnt, cn, cm, cn_lim, cs} = '0;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    for (i = 0; i < 12; i++) do_row(rows[i]);
    $display("test registers done");
    // Power-up in counter mode
    tk_app <= 0;
    tk_irq <= 0;
    irq_seen <= 1'b0;
    irq_cnt <= 0;
    pu <= 1'b1;
    @(posedge clk);
    pu <= 1'b0;
    @(posedge clk);
    chk("xtal_en", 32'h1, {31'h0, xen});
    chk("rc_fast", 32'h1, {31'h0, rcf});
    for (n = 0; n < 2000 && app !== 1'b1; n++) @(posedge clk);
    chk("apply_ticks", 32'h4, 32'(tk_app));
    apb(1'b0, ADDR_TRIM_SET, 32'h0, r, e);
    chk("trim", 32'h5a, r);
    chk("cap", 32'h7a, {20'h0, capt, capb});
    for (n = 0; n < 2000 && stl !== 1'b1; n++) @(posedge clk);
    chk("rc_slow", 32'h0, {31'h0, rcf});
    apb(1'b0, ADDR_STATUS, 32'h0, r, e);
    chk("status", 32'h3, r & 32'h3);
    for (n = 0; n < 2000 && irq_seen !== 1'b1; n++) @(posedge clk);
    chk("irq_ticks", 32'h30, 32'(tk_irq));
    repeat (4) @(posedge clk);
    chk("irq_pulses", 32'h1, 32'(irq_cnt));
    $display("test power-up done");
    // Wake-up in current mode
    apb(1'b1, ADDR_TRIM_CTRL, 32'h00030401, r, e);
    tk_lp <= 0;
    wk <= 1'b1;
    @(posedge clk);
    wk <= 1'b0;
    for (i = 0; i < 5; i++) begin
      @(posedge clk);
      while (lp_t !== 1'b1) @(posedge clk);
    end
    repeat (3) @(posedge clk);
    chk("no_early", 32'h0, {31'h0, app});
    drop_req <= 1'b1;
    @(posedge clk);
    drop_req <= 1'b0;
    for (n = 0; n < 2000 && app !== 1'b1; n++) @(posedge clk);
    apb(1'b0, ADDR_RDY_CAP, 32'h0, r, e);
    chk("capture", 32'(tk_lp), r);
    $display("test wake-up done");
    // Calibration of every source, the slow RC with a zero cycle count
    for (i = 0; i < 4; i++) begin
      cn_lim = (i == 0) ? 0 : i + 3;
      cs = i;
      cn = 0;
      cm = 0;
      apb(1'b1, ADDR_CAL_N, 32'(cn_lim), r, e);
      apb(1'b1, ADDR_CAL_SEL, {29'h0, 1'b1, 2'(i)}, r, e);
      cal_on <= (cn_lim != 0);
      apb(1'b0, ADDR_CAL_SEL, 32'h0, r, e);
      if (cn_lim != 0) chk("go", {29'h0, 1'b1, 2'(i)}, r);
      apb(1'b1, ADDR_CAL_N, 32'h99, r, e);
      n = 0;
      do begin
        apb(1'b0, ADDR_CAL_SEL, 32'h0, r, e);
        n++;
      end while (r[2] !== 1'b0 && n < 100);
      apb(1'b0, ADDR_CAL_HI, 32'h0, hi, e);
      apb(1'b0, ADDR_CAL_LO, 32'h0, r, e);
      chk("count_m", 32'(cm), {hi[15:0], r[15:0]});
      apb(1'b0, ADDR_CAL_N, 32'h0, r, e);
      chk("cal_n", (i == 0) ? 32'h99 : 32'(cn_lim), r);
      apb(1'b0, ADDR_CAL_HI, 32'h0, r, e);
      chk("hold", hi, r);
    end
    $display("test calibration done");
    apb(1'b0, 8'hfc, 32'h0, r, e);
    chk("unmapped", 32'h1, {31'h0, e});
    // Reset in mid-run
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk("rst_out", 32'h0, {15'h0, capt, capb, irq, xen, rcf, app, stl});
    for (i = 0; i < 5; i++) begin
      apb(1'b0, rst_rows[i].a, 32'h0, r, e);
      chk("rst_reg", rst_rows[i].x, r);
    end
    $display("test reset done");
    end_sim();
  end
endmodule
`default_nettype wire
